// *** inc/tmc_pkg.sv ***
// Constants shared by the terminal miscellaneous control block.
// Assumes a single 10 MHz system clock and byte addressing on AXI4-Lite.
package tmc_pkg;

   // Clock and master clear timing.
   localparam int MCLK_PERIOD_NS = 100;
   localparam int MCLR_MIN_NS    = 100;
   localparam int MCLR_MIN_CYC_RAW =
      (MCLR_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int MCLR_MIN_CYC   = (MCLR_MIN_CYC_RAW < 1) ? 1
                                   : MCLR_MIN_CYC_RAW;

   // Register bus geometry.
   localparam int ADDR_W = 5;

   // Register byte offsets.
   localparam logic [4:0] OFS_CFG1    = 5'h00;
   localparam logic [4:0] OFS_CFG2    = 5'h04;
   localparam logic [4:0] OFS_CMD     = 5'h08;
   localparam logic [4:0] OFS_STATUS  = 5'h0C;
   localparam logic [4:0] OFS_TIMETAG = 5'h10;

   // Configuration 1 fields.
   localparam int CFG1_MODE_LSB = 0;
   localparam int CFG1_EXT_BIT  = 7;
   localparam int CFG1_SSF_BIT  = 8;
   localparam logic [15:0] CFG1_RESET = 16'h0100;

   // Configuration 2 fields.
   localparam int CFG2_TTSRC_LSB = 7;
   localparam logic [2:0]  TTSRC_EXT  = 3'h7;
   localparam logic [15:0] CFG2_RESET = 16'h0000;

   // Command register bits (write one to act).
   localparam int CMD_MON_GO  = 0;
   localparam int CMD_MON_RST = 1;
   localparam int CMD_TT_CLR  = 2;

   // Status register bits.
   localparam int ST_IN_CMD  = 0;
   localparam int ST_ONLINE  = 1;
   localparam int ST_SUBSYSTEM_FLAG_TRIGGER_N  = 2;
   localparam int ST_TXEN_A  = 3;
   localparam int ST_TXEN_B  = 4;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operating modes.
   typedef enum logic [1:0] {
      TMC_MODE_BC   = 2'b00,
      TMC_MODE_RT   = 2'b01,
      TMC_MODE_MMON = 2'b10,
      TMC_MODE_WMON = 2'b11
   } tmc_mode_t;

endpackage : tmc_pkg

// *** logic/tmc_sync_edge.sv ***
// Two-flop synchroniser for one pin, with synced level and rising-edge pulse.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module tmc_sync_edge #(
   parameter logic INIT = 1'b1
) (
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic arst_n,
   // Pin and results.
   input  wire logic pin,
   output logic      level,
   output logic      rise
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tmc_sync_st_t;

   tmc_sync_st_t st_reg;
   tmc_sync_st_t st_next;

   // The first stage feeds only the second stage.
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = pin;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
   end

   // Register the state.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '{s1: INIT, s2: INIT, s3: INIT};
      end else begin
         st_reg <= st_next;
      end
   end

   // One pulse per low-to-high transition of the synced level.
   assign level = st_reg.s2;
   assign rise  = st_reg.s2 & ~st_reg.s3;

endmodule : tmc_sync_edge
`default_nettype wire

// *** logic/tmc_time_tag.sv ***
// Sixteen-bit time-tag counter with increment and clear.
// Assumes both controls are single-cycle pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
module tmc_time_tag (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // Controls.
   input  wire logic        inc,
   input  wire logic        clr,
   // Count.
   output logic [15:0]      count
);

   typedef struct packed {
      logic [15:0] cnt;
   } tmc_tt_st_t;

   tmc_tt_st_t st_reg;
   tmc_tt_st_t st_next;

   // Clear wins; the counter wraps at the top.
   always_comb begin
      st_next = st_reg;
      if (clr) begin
         st_next.cnt = 16'h0000;
      end else if (inc) begin
         st_next.cnt = st_reg.cnt + 16'h0001;
      end
   end

   // Register the state.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.cnt;

endmodule : tmc_time_tag
`default_nettype wire

// *** logic/tmc_top.sv ***
// Terminal miscellaneous control: in-command, trigger, time tag, inhibits.
// Assumes the protocol engine shares mclk and software uses AXI4-Lite.
//
// Overview of operation
// - Active-low master clear of at least 100 ns resets all state.
// - Bus controller mode: in-command low for each whole message cycle.
// - Terminal or message monitor: low from command word until sequence done.
// - Word monitor: low after monitor go, high again after reset command.
// - Terminal mode: asserted flag input sets the status word subsystem flag.
// - Low flag input overrides a one in the software flag bit.
// - Controller mode, bit 7 set: trigger rising edge starts current frame.
// - Word monitor, bit 7 set: trigger rising edge raises monitor trigger.
// - External time-tag source selected: each tick increments the counter.
// - Each channel's inhibit at one disables that channel's transmitter.
`timescale 1ns/1ps
`default_nettype none
module tmc_top (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // AXI4-Lite write address.
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [4:0]  s_axi_awaddr,
   // AXI4-Lite write data.
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response.
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address.
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [4:0]  s_axi_araddr,
   // AXI4-Lite read data.
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Device pins.
   input  wire logic        subsystem_flag_trigger_n,
   input  wire logic        tag_clock,
   input  wire logic        transmit_inhibit_chan_a,
   input  wire logic        transmit_inhibit_chan_b,
   output logic             in_command_n,
   // Protocol engine, same clock.
   input  wire logic        bc_msg_busy,
   input  wire logic        cmd_word_rcvd,
   input  wire logic        msg_seq_done,
   output logic             bc_start,
   output logic             monitor_trigger,
   output logic             rt_subsystem_flag,
   output logic             tx_enable_a,
   output logic             tx_enable_b,
   output logic [15:0]      time_tag
);

   typedef struct packed {
      logic        aw_full;
      logic [4:0]  aw_addr;
      logic        w_full;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [15:0] cfg1;
      logic [15:0] cfg2;
      logic        msg_cmd;
      logic        online;
      logic        in_cmd;
      logic        bc_start;
      logic        mon_trig;
      logic        ss_flag;
      logic        tx_en_a;
      logic        tx_en_b;
      logic        tt_clr;
   } tmc_top_st_t;

   tmc_top_st_t st_reg;
   tmc_top_st_t st_next;

   logic        ss_level;
   logic        ss_rise;
   logic        tag_rise;
   logic        inh_a;
   logic        inh_b;
   logic [15:0] tt_count;
   logic        tt_inc;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   // Flag pin idles high; start high so release gives no false edge.
   tmc_sync_edge #(.INIT(1'b1)) u_sync_ss (
      .mclk   (mclk),
      .arst_n (arst_n),
      .pin    (subsystem_flag_trigger_n),
      .level  (ss_level),
      .rise   (ss_rise)
   );

   // Tag clock may be tied to either rail.
   tmc_sync_edge #(.INIT(1'b1)) u_sync_tag (
      .mclk   (mclk),
      .arst_n (arst_n),
      .pin    (tag_clock),
      .level  (),
      .rise   (tag_rise)
   );

   // Inhibits start asserted so no transmitter fires before they settle.
   tmc_sync_edge #(.INIT(1'b1)) u_sync_inh_a (
      .mclk   (mclk),
      .arst_n (arst_n),
      .pin    (transmit_inhibit_chan_a),
      .level  (inh_a),
      .rise   ()
   );

   tmc_sync_edge #(.INIT(1'b1)) u_sync_inh_b (
      .mclk   (mclk),
      .arst_n (arst_n),
      .pin    (transmit_inhibit_chan_b),
      .level  (inh_b),
      .rise   ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Time tag.

   // Only the external source counts here; other codes hold the count.
   assign tt_inc = tag_rise &
      (st_reg.cfg2[tmc_pkg::CFG2_TTSRC_LSB +: 3] == tmc_pkg::TTSRC_EXT);

   tmc_time_tag u_time_tag (
      .mclk   (mclk),
      .arst_n (arst_n),
      .inc    (tt_inc),
      .clr    (st_reg.tt_clr),
      .count  (tt_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus slave, control and pin outputs.

   always_comb begin
      tmc_pkg::tmc_mode_t mode;
      logic               ext_en;
      logic               do_wr;
      logic               mon_go;
      logic               mon_rst;

      st_next  = st_reg;
      mode     = tmc_pkg::tmc_mode_t'(
                    st_reg.cfg1[tmc_pkg::CFG1_MODE_LSB +: 2]);
      ext_en   = st_reg.cfg1[tmc_pkg::CFG1_EXT_BIT];
      do_wr    = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;
      mon_go   = 1'b0;
      mon_rst  = 1'b0;
      st_next.tt_clr = 1'b0;

      // Hold write address and data until both are present.
      if (s_axi_awvalid && !st_reg.aw_full) begin
         st_next.aw_full = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_full) begin
         st_next.w_full = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end

      // Perform the write and raise the response.
      if (do_wr) begin
         st_next.aw_full = 1'b0;
         st_next.w_full  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = tmc_pkg::RESP_OKAY;
         case (st_reg.aw_addr)
            tmc_pkg::OFS_CFG1: begin
               if (st_reg.w_strb[0]) st_next.cfg1[7:0]  = st_reg.w_data[7:0];
               if (st_reg.w_strb[1]) st_next.cfg1[15:8] = st_reg.w_data[15:8];
            end
            tmc_pkg::OFS_CFG2: begin
               if (st_reg.w_strb[0]) st_next.cfg2[7:0]  = st_reg.w_data[7:0];
               if (st_reg.w_strb[1]) st_next.cfg2[15:8] = st_reg.w_data[15:8];
            end
            tmc_pkg::OFS_CMD: begin
               if (st_reg.w_strb[0]) begin
                  mon_go  = st_reg.w_data[tmc_pkg::CMD_MON_GO];
                  mon_rst = st_reg.w_data[tmc_pkg::CMD_MON_RST];
                  st_next.tt_clr = st_reg.w_data[tmc_pkg::CMD_TT_CLR];
               end
            end
            tmc_pkg::OFS_STATUS, tmc_pkg::OFS_TIMETAG: begin
               st_next.bresp = tmc_pkg::RESP_OKAY;
            end
            default: begin
               st_next.bresp = tmc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // Read: accept when no answer is pending, answer next cycle.
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !st_reg.rvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = tmc_pkg::RESP_OKAY;
         st_next.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            tmc_pkg::OFS_CFG1:    st_next.rdata[15:0] = st_reg.cfg1;
            tmc_pkg::OFS_CFG2:    st_next.rdata[15:0] = st_reg.cfg2;
            tmc_pkg::OFS_CMD:     st_next.rdata       = 32'h0000_0000;
            tmc_pkg::OFS_STATUS: begin
               st_next.rdata[tmc_pkg::ST_IN_CMD] = st_reg.in_cmd;
               st_next.rdata[tmc_pkg::ST_ONLINE] = st_reg.online;
               st_next.rdata[tmc_pkg::ST_SUBSYSTEM_FLAG_TRIGGER_N] = st_reg.ss_flag;
               st_next.rdata[tmc_pkg::ST_TXEN_A] = st_reg.tx_en_a;
               st_next.rdata[tmc_pkg::ST_TXEN_B] = st_reg.tx_en_b;
            end
            tmc_pkg::OFS_TIMETAG: st_next.rdata[15:0] = tt_count;
            default:              st_next.rresp = tmc_pkg::RESP_SLVERR;
         endcase
      end

      // Message flag for terminal and message monitor; a new command wins.
      if (cmd_word_rcvd) begin
         st_next.msg_cmd = 1'b1;
      end else if (msg_seq_done) begin
         st_next.msg_cmd = 1'b0;
      end

      // Word monitor on-line; go wins over reset in the same write.
      if (mon_go) begin
         st_next.online = 1'b1;
      end else if (mon_rst) begin
         st_next.online = 1'b0;
      end

      // In-command source by mode.
      unique case (mode)
         tmc_pkg::TMC_MODE_BC:   st_next.in_cmd = bc_msg_busy;
         tmc_pkg::TMC_MODE_RT,
         tmc_pkg::TMC_MODE_MMON: st_next.in_cmd = st_next.msg_cmd;
         tmc_pkg::TMC_MODE_WMON: st_next.in_cmd = st_next.online;
      endcase

      // Edge-triggered start and monitor trigger, gated by bit 7.
      st_next.bc_start = ss_rise & ext_en &
                         (mode == tmc_pkg::TMC_MODE_BC);
      st_next.mon_trig = ss_rise & ext_en &
                         (mode == tmc_pkg::TMC_MODE_WMON);

      // Flag set by a low pin or a zero software bit, terminal mode only.
      st_next.ss_flag = (mode == tmc_pkg::TMC_MODE_RT) &
         (~ss_level | ~st_reg.cfg1[tmc_pkg::CFG1_SSF_BIT]);

      // Transmitter enables follow the synced inhibits.
      st_next.tx_en_a = ~inh_a;
      st_next.tx_en_b = ~inh_b;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; master clear returns everything to power-on values.

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg      <= '0;
         st_reg.cfg1 <= tmc_pkg::CFG1_RESET;
         st_reg.cfg2 <= tmc_pkg::CFG2_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign s_axi_awready     = ~st_reg.aw_full;
   assign s_axi_wready      = ~st_reg.w_full;
   assign s_axi_bvalid      = st_reg.bvalid;
   assign s_axi_bresp       = st_reg.bresp;
   assign s_axi_arready     = ~st_reg.rvalid;
   assign s_axi_rvalid      = st_reg.rvalid;
   assign s_axi_rdata       = st_reg.rdata;
   assign s_axi_rresp       = st_reg.rresp;
   assign in_command_n      = ~st_reg.in_cmd;
   assign bc_start          = st_reg.bc_start;
   assign monitor_trigger   = st_reg.mon_trig;
   assign rt_subsystem_flag = st_reg.ss_flag;
   assign tx_enable_a       = st_reg.tx_en_a;
   assign tx_enable_b       = st_reg.tx_en_b;
   assign time_tag          = tt_count;

endmodule : tmc_top
`default_nettype wire

// *** verification/tmc_pin_host.sv ***
// Board-side model driving the terminal's control pins.
// Assumes callers sit on mclk; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_host (
   // Clock.
   input  wire logic mclk,
   // Pins toward the terminal.
   output logic      flag_trig_n,
   output logic      tag_clk,
   output logic      inh_a,
   output logic      inh_b
);
   // Idle board levels: flag released, tick low, transmitters allowed.
   initial begin
      flag_trig_n = 1'h1;
      tag_clk = 1'h0;
      inh_a = 1'h0;
      inh_b = 1'h0;
   end
   // Hold the pins for n cycles so each change is seen whole.
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
   endtask : hold
   // Low then high gives one rising edge.
   task automatic trig_pulse();
      hold(1);
      flag_trig_n <= 1'h0;
      hold(8);
      flag_trig_n <= 1'h1;
      hold(8);
   endtask : trig_pulse
   // Set the flag level and let it pass the synchroniser.
   task automatic set_flag(input logic v);
      hold(1);
      flag_trig_n <= v;
      hold(6);
   endtask : set_flag
   // One external time-tag tick.
   task automatic tick();
      hold(1);
      tag_clk <= 1'h1;
      hold(4);
      tag_clk <= 1'h0;
      hold(4);
   endtask : tick
   // Set both transmitter inhibits.
   task automatic set_inh(input logic a, input logic b);
      hold(1);
      inh_a <= a;
      inh_b <= b;
      hold(6);
   endtask : set_inh
endmodule : tmc_pin_host
`default_nettype wire

// *** verification/tmc_top_chk.sv ***
// Port checker for the terminal control block, bound into its top.
// Assumes one clock domain, mclk, with asynchronous active-low arst_n.
`timescale 1ns/1ps
`default_nettype none
module tmc_chk (
   // Clock and reset.
   input wire logic        mclk,
   input wire logic        arst_n,
   // Pins and event outputs.
   input wire logic        subsystem_flag_trigger_n,
   input wire logic        tag_clock,
   input wire logic        transmit_inhibit_chan_a,
   input wire logic        transmit_inhibit_chan_b,
   input wire logic        in_command_n,
   input wire logic        bc_start,
   input wire logic        monitor_trigger,
   input wire logic        tx_enable_a,
   input wire logic        tx_enable_b,
   input wire logic [15:0] time_tag
);
   ////////////////////////////////////////////////////////////////////////
   // Saturating age since reset, so pipeline checks skip the refill.
   logic [2:0] age_reg;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) age_reg <= 3'h0;
      else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   property p_clear;
      $rose(arst_n) |-> in_command_n && !bc_start && time_tag == 16'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("outputs not at clear state after reset");
   property p_start_len;
      bc_start |=> !bc_start;
   endproperty
   a_start_len: assert property (p_start_len)
      else $error("start pulse longer than one cycle");
   property p_trig_len;
      monitor_trigger |=> !monitor_trigger;
   endproperty
   a_trig_len: assert property (p_trig_len)
      else $error("monitor trigger longer than one cycle");
   property p_trig_src;
      (bc_start || monitor_trigger) |-> $past(subsystem_flag_trigger_n, 3)
         && !$past(subsystem_flag_trigger_n, 4);
   endproperty
   a_trig_src: assert property (p_trig_src)
      else $error("event without a matching pin rising edge");
   property p_one_kind;
      !(bc_start && monitor_trigger);
   endproperty
   a_one_kind: assert property (p_one_kind)
      else $error("start and monitor trigger together");
   property p_txa;
      age_reg == 3'h7 && $stable(transmit_inhibit_chan_a)
         && $past(transmit_inhibit_chan_a, 3) == transmit_inhibit_chan_a
         |-> tx_enable_a == !transmit_inhibit_chan_a;
   endproperty
   a_txa: assert property (p_txa)
      else $error("channel A enable disagrees with inhibit");
   property p_txb;
      age_reg == 3'h7 && $stable(transmit_inhibit_chan_b)
         && $past(transmit_inhibit_chan_b, 3) == transmit_inhibit_chan_b
         |-> tx_enable_b == !transmit_inhibit_chan_b;
   endproperty
   a_txb: assert property (p_txb)
      else $error("channel B enable disagrees with inhibit");
   property p_tag;
      $changed(time_tag) |-> time_tag == 16'h0
         || (time_tag == $past(time_tag) + 16'h1 && $past(tag_clock, 3)
         && !$past(tag_clock, 4));
   endproperty
   a_tag: assert property (p_tag)
      else $error("time tag moved without one tick");
endmodule : tmc_chk
bind tmc_top tmc_chk i_chk (
   .mclk(mclk), .arst_n(arst_n),
   .subsystem_flag_trigger_n(subsystem_flag_trigger_n),
   .tag_clock(tag_clock),
   .transmit_inhibit_chan_a(transmit_inhibit_chan_a),
   .transmit_inhibit_chan_b(transmit_inhibit_chan_b),
   .in_command_n(in_command_n), .bc_start(bc_start),
   .monitor_trigger(monitor_trigger), .tx_enable_a(tx_enable_a),
   .tx_enable_b(tx_enable_b), .time_tag(time_tag)
);
`default_nettype wire

// *** verification/tmc_top_test.sv ***
// Self-checking bench for the terminal control block.
// Assumes the checker is bound in and the pin model sits beside the block.
`timescale 1ns/1ps
`default_nettype none
module tmc_top_test;
   logic        mclk, arst_n, awv, awr, wv, wr, bv, bb, arv, arr, rv, rr;
   logic        busy, cmdw, done, flag_n, tag, inh_a, inh_b;
   logic        in_command_n_n, start, mtrig, rtflag, txa, txb;
   logic [4:0]  awa, ara;
   logic [3:0]  ws;
   logic [31:0] wd, rd, got;
   logic [1:0]  br, rrs, resp, m;
   logic [15:0] ttag;
   int          mismatches, n_compared, n_start, n_mtrig, k;
   localparam logic [31:0] SLVERR32 = {30'h0, tmc_pkg::RESP_SLVERR};
   ////////////////////////////////////////////////////////////////////////
   // Free-running system clock from the board source.
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end
   tmc_top i_dut (
      .mclk(mclk), .arst_n(arst_n),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bb),
      .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .s_axi_rdata(rd), .s_axi_rresp(rrs),
      .subsystem_flag_trigger_n(flag_n), .tag_clock(tag),
      .transmit_inhibit_chan_a(inh_a), .transmit_inhibit_chan_b(inh_b),
      .in_command_n(in_command_n_n), .bc_msg_busy(busy), .cmd_word_rcvd(cmdw),
      .msg_seq_done(done), .bc_start(start), .monitor_trigger(mtrig),
      .rt_subsystem_flag(rtflag), .tx_enable_a(txa), .tx_enable_b(txb),
      .time_tag(ttag)
   );
   tmc_pin_host i_host (
      .mclk(mclk), .flag_trig_n(flag_n), .tag_clk(tag),
      .inh_a(inh_a), .inh_b(inh_b)
   );
   // Count event pulses mid-cycle, where the outputs are settled.
   always @(negedge mclk) begin
      if (start === 1'h1) n_start++;
      if (mtrig === 1'h1) n_mtrig++;
   end
   ////////////////////////////////////////////////////////////////////////
   // Expected register and flag values.
   function automatic logic [31:0] cfg1(logic [1:0] md, logic e, logic sw);
      return {23'h0, sw, e, 5'h0, md};
   endfunction : cfg1
   function automatic logic exp_flag(logic [1:0] md, logic sw, logic pn);
      return (md == 2'h1) && (!pn || !sw);
   endfunction : exp_flag
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic chk1(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s: expected %b, seen %b", nm, e, g);
      end
   endtask : chk1
   task automatic chkw(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chkw
   // A wait that runs out of its bound ends the run.
   task automatic bound(inout int n);
      n++;
      if (n > 40) begin
         mismatches++;
         $display("wrong value bus answer: expected within 40, seen none");
         complete_run();
      end
   endtask : bound
   // One bus write; address and data offered together, each released.
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
      int   n;
      logic ta, tw, tb;
      n = 0;
      @(posedge mclk);
      awa <= a;
      wd <= d;
      ws <= 4'hF;
      awv <= 1'h1;
      wv <= 1'h1;
      bb <= 1'h1;
      do begin
         @(negedge mclk);
         ta = awv && awr;
         tw = wv && wr;
         tb = bv;
         resp = br;
         @(posedge mclk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
         bound(n);
      end while (!tb);
      bb <= 1'h0;
   endtask : axi_wr
   // One bus read; data and response land in got and resp.
   task automatic axi_rd(input logic [4:0] a);
      int   n;
      logic ta, tr;
      n = 0;
      @(posedge mclk);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      do begin
         @(negedge mclk);
         ta = arv && arr;
         tr = rv;
         got = rd;
         resp = rrs;
         @(posedge mclk);
         if (ta) arv <= 1'h0;
         bound(n);
      end while (!tr);
      rr <= 1'h0;
   endtask : axi_rd
   // Protocol engine inputs from the next rising edge, held until the next call.
   task automatic eng(input logic b, input logic c, input logic d);
      @(posedge mclk);
      busy <= b;
      cmdw <= c;
      done <= d;
   endtask : eng
   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      arst_n = 1'h0;
      {awv, wv, bb, arv, rr, busy, cmdw, done} = 8'h0;
      {awa, ara, ws} = 14'h0;
      wd = 32'h0;
      void'($urandom(15));
      repeat (6) @(posedge mclk);
      arst_n <= 1'h1;
      axi_rd(tmc_pkg::OFS_CFG1);
      chkw("cfg1 reset", {16'h0, tmc_pkg::CFG1_RESET}, got);
      eng(1'h1, 1'h0, 1'h0);
      repeat (2) @(negedge mclk);
      chk1("in_command_n busy", 1'h0, in_command_n_n);
      eng(1'h0, 1'h0, 1'h0);
      repeat (2) @(negedge mclk);
      chk1("in_command_n idle", 1'h1, in_command_n_n);
      $display("test controller in-command ended");
      // External start, disabled then enabled, random count of edges.
      for (int e = 0; e < 2; e++) begin
         axi_wr(tmc_pkg::OFS_CFG1, cfg1(2'h0, e[0], 1'h1));
         k = 1 + $urandom % 3;
         n_start = 0;
         repeat (k) i_host.trig_pulse();
         chkw("bc_start count", e ? k : 0, n_start);
      end
      $display("test external start ended");
      // Flag in terminal and controller modes, pin against software bit.
      for (int i = 0; i < 8; i++) begin
         m = {1'h0, i[2]};
         axi_wr(tmc_pkg::OFS_CFG1, cfg1(m, 1'h0, i[0]));
         i_host.set_flag(i[1]);
         @(negedge mclk);
         chk1("rt flag", exp_flag(m, i[0], i[1]), rtflag);
      end
      // Command word to end of sequence, terminal and message monitor.
      for (int j = 1; j < 3; j++) begin
         axi_wr(tmc_pkg::OFS_CFG1, cfg1(j[1:0], 1'h0, 1'h1));
         eng(1'h0, 1'h1, 1'h0);
         eng(1'h0, 1'h0, 1'h0);
         @(negedge mclk);
         chk1("in_command_n cmd", 1'h0, in_command_n_n);
         eng(1'h0, 1'h0, 1'h1);
         eng(1'h0, 1'h0, 1'h0);
         @(negedge mclk);
         chk1("in_command_n done", 1'h1, in_command_n_n);
      end
      $display("test terminal flag and in-command ended");
      n_mtrig = 0;
      axi_wr(tmc_pkg::OFS_CFG1, cfg1(2'h3, 1'h1, 1'h1));
      axi_wr(tmc_pkg::OFS_CMD, 32'h1);
      @(negedge mclk);
      chk1("in_command_n go", 1'h0, in_command_n_n);
      axi_rd(tmc_pkg::OFS_STATUS);
      chkw("status go", 32'h1B, got);
      i_host.trig_pulse();
      chkw("monitor_trigger count", 32'h1, n_mtrig);
      axi_wr(tmc_pkg::OFS_CMD, 32'h2);
      @(negedge mclk);
      chk1("in_command_n reset", 1'h1, in_command_n_n);
      $display("test word monitor ended");
      axi_wr(tmc_pkg::OFS_CFG2, {22'h0, tmc_pkg::TTSRC_EXT, 7'h0});
      axi_wr(tmc_pkg::OFS_CMD, 32'h4);
      k = 1 + $urandom % 6;
      repeat (k) i_host.tick();
      axi_rd(tmc_pkg::OFS_TIMETAG);
      chkw("time tag ext", k, got);
      chkw("time tag port", k, {16'h0, ttag});
      axi_wr(tmc_pkg::OFS_CFG2, 32'h0);
      repeat (2) i_host.tick();
      axi_rd(tmc_pkg::OFS_TIMETAG);
      chkw("time tag held", k, got);
      // One-cycle master clear in mid-run.
      @(posedge mclk);
      arst_n <= 1'h0;
      @(posedge mclk);
      arst_n <= 1'h1;
      axi_rd(tmc_pkg::OFS_TIMETAG);
      chkw("time tag cleared", 32'h0, got);
      $display("test time tag and clear ended");
      for (int i = 0; i < 4; i++) begin
         i_host.set_inh(i[0], i[1]);
         @(negedge mclk);
         chk1("tx_enable_a", !i[0], txa);
         chk1("tx_enable_b", !i[1], txb);
      end
      $display("test inhibits ended");
      axi_rd(5'h14);
      chkw("bad read resp", SLVERR32, {30'h0, resp});
      chkw("bad read data", 32'h0, got);
      axi_wr(5'h18, 32'hFFFF);
      chkw("bad write resp", SLVERR32, {30'h0, resp});
      $display("test unmapped ended");
      complete_run();
   end
endmodule : tmc_top_test
`default_nettype wire
